//--- verilog/tlc_pkg.sv
package tlc_pkg;
	// ==========================================================
	// sizing
	localparam int NUM_BEARERS   = 4;
	localparam int BEARER_W      = 2;
	localparam int NUM_FMT       = 4;
	localparam int SIZE_W        = 16;
	localparam int CNT_W         = 32;
	localparam int BUF_MIN_BYTES = 10240;

	// ==========================================================
	// register map: page in PADDR[7:4], word slot in PADDR[3:2]
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CNT   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_FMT0  = 8'h10;
	localparam logic [7:0] OFS_BCFG0 = 8'h20;
	localparam logic [3:0] PAGE_MISC = 4'h0;
	localparam logic [3:0] PAGE_FMT  = 4'h1;
	localparam logic [3:0] PAGE_BCFG = 4'h2;

	// control word
	localparam int CTRL_TEST_BIT = 0;
	localparam int CTRL_MTCH_BIT = 1;
	localparam int CTRL_W        = 2;
	// status word
	localparam int STAT_MODE3_BIT = 8;
	// bearer configuration word
	localparam int BCFG_SETUP_BIT = 16;
	localparam int BCFG_BIDIR_BIT = 17;
	localparam int BCFG_PDCP_BIT  = 18;
	localparam int BCFG_UP_BIT    = 19;
	localparam int BCFG_W         = 20;
	localparam int BCFG_MODE_LSB  = 20;
	localparam int BCFG_CLOSED_BIT = 22;

	// ==========================================================
	// loop modes
	localparam logic [1:0] MODE_ONE   = 2'h1;
	localparam logic [1:0] MODE_TWO   = 2'h2;
	localparam logic [1:0] MODE_THREE = 2'h3;

	typedef struct packed {
		logic [7:0]          data;
		logic                last;
		logic [BEARER_W-1:0] bearer;
	} tlc_dl_beat_t;

	typedef struct packed {
		logic [7:0]          data;
		logic                last;
		logic [BEARER_W-1:0] bearer;
		logic                pdcp;
	} tlc_ul_beat_t;

	typedef struct packed {
		logic       open;
		logic [1:0] mode;
	} tlc_cmd_t;

	typedef struct packed {
		logic close_done;
		logic open_done;
	} tlc_ack_t;
endpackage

//--- verilog/tlc_sdu_mem.sv
`timescale 1ns/1ps
module tlc_sdu_mem #(
	parameter int DEPTH = 10240,
	parameter int WIDTH = 8,
	parameter int AW    = 14
) (
	// clock
	input  wire logic             clk,
	// write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// read side, data one cycle after rd_en
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_ff
);
	logic [WIDTH-1:0] mem [DEPTH];

	// refused at elaboration, before any address can alias
	if (DEPTH > (1 << AW))
		$error("address too narrow for depth");

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rd_en) begin
			rd_data_ff <= mem[rd_addr];
		end
	end
endmodule

//--- verilog/tlc_fmt_sel.sv
`timescale 1ns/1ps
module tlc_fmt_sel #(
	parameter int NUM = 4,
	parameter int W   = 16
) (
	// configured uplink formats, zero means unused
	input  wire logic [NUM-1:0][W-1:0] fmt,
	// bytes to return: block plus crc
	input  wire logic [W-1:0]          need,
	// chosen uplink block size
	output logic      [W-1:0]          size
);
	logic [W-1:0] fit_c [NUM+1];
	logic         fit_v [NUM+1];
	logic [W-1:0] big_c [NUM+1];

	assign fit_c[0] = '0;
	assign fit_v[0] = 1'b0;
	assign big_c[0] = '0;

	// chained scan: smallest fitting format, and the biggest overall
	for (genvar i = 0; i < NUM; i++) begin : g_fmt
		logic fits;
		assign fits = (fmt[i] != '0) && (fmt[i] >= need);
		assign fit_v[i+1] = fit_v[i] | fits;
		assign fit_c[i+1] = (fits && (!fit_v[i] || fmt[i] < fit_c[i])) ?
			fmt[i] : fit_c[i];
		assign big_c[i+1] = (fmt[i] > big_c[i]) ? fmt[i] : big_c[i];
	end

	// no fit: biggest format, the caller truncates
	assign size = fit_v[NUM] ? fit_c[NUM] : big_c[NUM];
endmodule

//--- verilog/tlc_loop_ctrl.sv
`timescale 1ns/1ps
// How it works
// - loops survive handover; bearer disconnect drops its loop at once
// - mode 1/2 close ignored without bidirectional bearer or test mode
// - close all bidirectional bearers; acknowledge only after loops run
// - unidirectional bearers never get a mode 1/2 loop
// - mode 3 close clears the sdu counter, counts, acknowledges
// - close while already closed is acknowledged without parsing
// - pdcp bearers loop back at the pdcp service point
// - bearers without pdcp loop back at the rlc service point
// - mode 1 uplink size from per-bearer setup element, else downlink size
// - uplink size zero returns nothing
// - equal sizes return the whole block unchanged
// - smaller uplink size returns the first K units
// - larger uplink size repeats the block, cutting the last copy
// - an uplink sdu that does not fit the buffer is dropped
// - at least 10 kbytes of loop buffer
// - mode 2 block plus crc truncated when no format is large enough
// - mode 2 picks the smallest fitting format, else the largest
// - mode 3 counter is 32 bits and wraps
// - open command opens every loop and is always acknowledged
module tlc_loop_ctrl #(
	parameter int BUF_BYTES = tlc_pkg::BUF_MIN_BYTES,
	parameter int AW        = 14
) (
	// clock and reset
	input  wire logic                 SYS_CLK,
	input  wire logic                 SYS_RST,
	// apb slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// test control commands from the radio link
	input  wire tlc_pkg::tlc_cmd_t    CMD_IN,
	input  wire logic                 CMD_VALID,
	output tlc_pkg::tlc_ack_t         ACK_OUT,
	// bearer disconnect and multicast sdu events
	input  wire logic [tlc_pkg::NUM_BEARERS-1:0] BEARER_DROP,
	input  wire logic                 MTCH_SDU,
	// downlink sdu stream
	input  wire tlc_pkg::tlc_dl_beat_t DL_IN,
	input  wire logic                 DL_VALID,
	output logic                      DL_READY,
	// uplink sdu stream
	output tlc_pkg::tlc_ul_beat_t     UL_OUT,
	output logic                      UL_VALID,
	input  wire logic                 UL_READY
);
	import tlc_pkg::*;

	default clocking cb_sys @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	// parameter checks, refused at elaboration
	if (BUF_BYTES < BUF_MIN_BYTES)
		$error("loop buffer below minimum");
	if (BUF_BYTES >= (1 << SIZE_W) || BUF_BYTES > (1 << AW))
		$error("loop buffer too large for counters");
	if (NUM_BEARERS != (1 << BEARER_W) || NUM_FMT > 4)
		$error("unsupported bearer or format count");

	typedef enum logic [2:0] {
		ST_RECV = 3'b001,
		ST_EVAL = 3'b010,
		ST_SEND = 3'b100
	} tlc_state_t;

	// ==========================================================
	// apb slave, three-cycle access
	logic [CTRL_W-1:0]           ctrl_ff;
	logic [NUM_FMT-1:0][SIZE_W-1:0] fmt_ff;
	logic [BCFG_W-1:0]           bcfg_ff [NUM_BEARERS];
	logic [CNT_W-1:0]            cnt_ff;
	logic                        mode3_ff;
	logic [NUM_BEARERS-1:0]      closed_vec;
	logic [1:0]                  mode_ff [NUM_BEARERS];
	logic [SIZE_W-1:0]           size_ff [NUM_BEARERS];
	logic                        setup_ff [NUM_BEARERS];
	logic [31:0]                 rd_val;
	logic                        hit;
	logic                        apb_wr;
	logic [1:0]                  slot;

	assign slot = PADDR[3:2];

	always_comb begin
		rd_val = '0;
		hit    = (PADDR[1:0] == 2'h0);
		case (PADDR[7:4])
			PAGE_MISC: begin
				if (PADDR == OFS_CTRL)
					rd_val[CTRL_W-1:0] = ctrl_ff;
				else if (PADDR == OFS_CNT)
					rd_val = cnt_ff;
				else if (PADDR == OFS_STAT) begin
					rd_val[NUM_BEARERS-1:0] = closed_vec;
					rd_val[STAT_MODE3_BIT]  = mode3_ff;
				end else
					hit = 1'b0;
			end
			PAGE_FMT: begin
				rd_val[SIZE_W-1:0] = fmt_ff[slot];
			end
			PAGE_BCFG: begin
				rd_val[BCFG_W-1:0] = bcfg_ff[slot];
				rd_val[BCFG_MODE_LSB +: 2] = mode_ff[slot];
				rd_val[BCFG_CLOSED_BIT] = closed_vec[slot];
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	assign apb_wr = PSEL & PENABLE & PREADY & PWRITE & hit;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PREADY  <= 1'b0;
			PRDATA  <= '0;
			PSLVERR <= 1'b0;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY  <= 1'b1;
			PRDATA  <= PWRITE ? '0 : rd_val;
			PSLVERR <= !hit;
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ctrl_ff <= '0;
			fmt_ff  <= '0;
			for (int i = 0; i < NUM_BEARERS; i++)
				bcfg_ff[i] <= '0;
		end else if (apb_wr) begin
			if (PADDR == OFS_CTRL)
				ctrl_ff <= PWDATA[CTRL_W-1:0];
			if (PADDR[7:4] == PAGE_FMT)
				fmt_ff[slot] <= PWDATA[SIZE_W-1:0];
			if (PADDR[7:4] == PAGE_BCFG)
				bcfg_ff[slot] <= PWDATA[BCFG_W-1:0];
		end
	end

	// ==========================================================
	// command interpreter
	logic [NUM_BEARERS-1:0] eligible;
	logic [NUM_BEARERS-1:0] bidir_vec;
	logic                   any_closed;
	logic                   close_req;
	logic                   open_req;
	logic                   mode12;
	logic                   accept12;
	logic                   accept3;
	logic                   reclose;
	tlc_ack_t               done_ff;

	assign close_req  = CMD_VALID & !CMD_IN.open;
	assign open_req   = CMD_VALID & CMD_IN.open;
	assign any_closed = (|closed_vec) | mode3_ff;
	assign mode12     = (CMD_IN.mode == MODE_ONE) | (CMD_IN.mode == MODE_TWO);
	assign accept12   = close_req & !any_closed & mode12 &
		ctrl_ff[CTRL_TEST_BIT] & (|eligible);
	assign accept3    = close_req & !any_closed &
		(CMD_IN.mode == MODE_THREE) & ctrl_ff[CTRL_MTCH_BIT] &
		ctrl_ff[CTRL_TEST_BIT];
	assign reclose    = close_req & any_closed;

	for (genvar i = 0; i < NUM_BEARERS; i++) begin : g_bearer
		logic kill;
		assign eligible[i] = bcfg_ff[i][BCFG_UP_BIT] &
			bcfg_ff[i][BCFG_BIDIR_BIT];
		assign kill = BEARER_DROP[i] | !bcfg_ff[i][BCFG_UP_BIT] | open_req;
		assign bidir_vec[i] = bcfg_ff[i][BCFG_BIDIR_BIT];
		always_ff @(posedge SYS_CLK) begin
			if (SYS_RST) begin
				closed_vec[i] <= 1'b0;
				mode_ff[i]    <= '0;
				size_ff[i]    <= '0;
				setup_ff[i]   <= 1'b0;
			end else if (kill) begin
				closed_vec[i] <= 1'b0;
			end else if (accept12 && eligible[i]) begin
				closed_vec[i] <= 1'b1;
				mode_ff[i]    <= CMD_IN.mode;
				size_ff[i]    <= bcfg_ff[i][SIZE_W-1:0];
				setup_ff[i]   <= bcfg_ff[i][BCFG_SETUP_BIT];
			end
		end
	end

	// acknowledge one cycle after the loops are in place
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			done_ff <= '0;
			ACK_OUT <= '0;
		end else begin
			done_ff.close_done <= accept12 | accept3 | reclose;
			done_ff.open_done  <= open_req;
			ACK_OUT <= done_ff;
		end
	end

	// mode 3 sdu counting, wraps silently past the top
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			mode3_ff <= 1'b0;
			cnt_ff   <= '0;
		end else begin
			if (open_req)
				mode3_ff <= 1'b0;
			else if (accept3)
				mode3_ff <= 1'b1;
			if (accept3)
				cnt_ff <= '0;
			else if (mode3_ff && MTCH_SDU)
				cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// ==========================================================
	// loopback datapath: store one sdu, then replay it
	tlc_state_t          state_ff;
	logic [SIZE_W-1:0]   len_ff;
	logic [SIZE_W-1:0]   ul_size_ff;
	logic [SIZE_W-1:0]   sent_ff;
	logic [AW-1:0]       rd_idx_ff;
	logic                rd_pend_ff;
	logic [BEARER_W-1:0] cur_ff;
	logic [SIZE_W-1:0]   fmt_size;
	logic [SIZE_W-1:0]   want;
	logic [7:0]          mem_q;
	logic                dl_take;
	logic                issue;
	logic [SIZE_W-1:0]   depth_c;

	assign depth_c = SIZE_W'(BUF_BYTES);
	assign dl_take = DL_VALID & DL_READY;
	assign issue   = (state_ff == ST_SEND) & !rd_pend_ff &
		(!UL_VALID | UL_READY) & (sent_ff != ul_size_ff);

	tlc_fmt_sel #(.NUM(NUM_FMT), .W(SIZE_W)) u_fmt (
		.fmt  (fmt_ff),
		.need (len_ff),
		.size (fmt_size)
	);

	// overlong downlink sdus keep only what the buffer holds
	tlc_sdu_mem #(.DEPTH(BUF_BYTES), .WIDTH(8), .AW(AW)) u_mem (
		.clk        (SYS_CLK),
		.wr_en      (dl_take && len_ff < depth_c),
		.wr_addr    (len_ff[AW-1:0]),
		.wr_data    (DL_IN.data),
		.rd_en      (issue),
		.rd_addr    (rd_idx_ff),
		.rd_data_ff (mem_q)
	);

	always_comb begin
		if (mode_ff[cur_ff] == MODE_TWO)
			want = fmt_size;
		else if (setup_ff[cur_ff])
			want = size_ff[cur_ff];
		else
			want = len_ff;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_ff   <= ST_RECV;
			DL_READY   <= 1'b0;
			len_ff     <= '0;
			ul_size_ff <= '0;
			cur_ff     <= '0;
		end else begin
			case (state_ff)
				ST_RECV: begin
					DL_READY <= !(dl_take && DL_IN.last);
					if (dl_take && len_ff < depth_c)
						len_ff <= len_ff + 1'b1;
					if (dl_take && DL_IN.last) begin
						cur_ff   <= DL_IN.bearer;
						state_ff <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					ul_size_ff <= want;
					// open loop, zero size or no room: nothing returned
					if (!closed_vec[cur_ff] || want == '0 ||
						want > depth_c) begin
						state_ff <= ST_RECV;
						len_ff   <= '0;
						DL_READY <= 1'b1;
					end else
						state_ff <= ST_SEND;
				end
				ST_SEND: begin
					if (UL_VALID && UL_READY && UL_OUT.last) begin
						state_ff <= ST_RECV;
						len_ff   <= '0;
						DL_READY <= 1'b1;
					end
				end
				default: begin
					state_ff <= ST_RECV;
				end
			endcase
		end
	end

	// replay wraps the read index at the stored length
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sent_ff    <= '0;
			rd_idx_ff  <= '0;
			rd_pend_ff <= 1'b0;
		end else begin
			rd_pend_ff <= issue;
			if (state_ff == ST_EVAL) begin
				sent_ff   <= '0;
				rd_idx_ff <= '0;
			end else if (issue) begin
				sent_ff <= sent_ff + 1'b1;
				if (SIZE_W'(rd_idx_ff) == len_ff - 1'b1)
					rd_idx_ff <= '0;
				else
					rd_idx_ff <= rd_idx_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			UL_VALID <= 1'b0;
			UL_OUT   <= '0;
		end else if (rd_pend_ff) begin
			UL_VALID      <= 1'b1;
			UL_OUT.data   <= mem_q;
			UL_OUT.last   <= (sent_ff == ul_size_ff);
			UL_OUT.bearer <= cur_ff;
			UL_OUT.pdcp   <= bcfg_ff[cur_ff][BCFG_PDCP_BIT];
		end else if (UL_READY) begin
			UL_VALID <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	// accepted uplink beats, counted apart from the replay counter
	logic [SIZE_W-1:0] ul_beats_ff;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST || state_ff == ST_EVAL) begin
			ul_beats_ff <= '0;
		end else if (UL_VALID && UL_READY) begin
			ul_beats_ff <= ul_beats_ff + 1'b1;
		end
	end

	a_close_ack: assert property (accept12 |=>
		(closed_vec == $past(eligible)) ##1 ACK_OUT.close_done)
		else $error("close not applied before ack");
	a_ignore_close: assert property ((close_req && mode12 &&
		!any_closed && !ctrl_ff[CTRL_TEST_BIT]) |-> ##2 !ACK_OUT.close_done)
		else $error("ineligible close acknowledged");
	a_no_unidir: assert property ((closed_vec & ~$past(closed_vec) &
		~$past(bidir_vec)) == '0)
		else $error("loop closed on unidirectional bearer");
	a_cnt_clear: assert property (accept3 |=>
		cnt_ff == '0 ##1 ACK_OUT.close_done)
		else $error("counter not cleared on mode 3 close");
	a_reclose_ack: assert property (reclose |=>
		$stable(closed_vec) ##1 ACK_OUT.close_done)
		else $error("repeated close mishandled");
	a_drop_loop: assert property (BEARER_DROP != '0 |=>
		(closed_vec & $past(BEARER_DROP)) == '0)
		else $error("loop kept after disconnect");
	a_open_ack: assert property (open_req |=>
		closed_vec == '0 && !mode3_ff ##1 ACK_OUT.open_done)
		else $error("open not acknowledged");
	a_zero_size: assert property ((state_ff == ST_EVAL &&
		(want == '0 || want > depth_c)) |=> state_ff == ST_RECV && !UL_VALID)
		else $error("empty or oversize sdu returned");
	a_ul_length: assert property ((UL_VALID && UL_READY &&
		UL_OUT.last) |-> ul_beats_ff + 1'b1 == ul_size_ff)
		else $error("uplink length differs from size");
	a_cnt_step: assert property ((mode3_ff && MTCH_SDU &&
		!accept3) |=> cnt_ff == $past(cnt_ff) + 1)
		else $error("sdu not counted");

	c_mode1: cover property (accept12 && CMD_IN.mode == MODE_ONE);
	c_mode2: cover property (accept12 && CMD_IN.mode == MODE_TWO);
	c_mode3: cover property (mode3_ff && MTCH_SDU);
	c_repeat: cover property (issue && rd_idx_ff == '0 && sent_ff != '0);
	c_open: cover property (open_req && any_closed);
endmodule

//--- dv/tlc_tester.sv
`timescale 1ns/1ps
module tlc_tester #(
	parameter int TMO = 20
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// orders from the bench
	input  wire logic              go,
	input  wire tlc_pkg::tlc_cmd_t cmd,
	output logic                   busy_ff,
	output logic                   acked_ff,
	output logic                   tmo_ff,
	// radio side of the block
	output tlc_pkg::tlc_cmd_t      cmd_out_ff,
	output logic                   cmd_valid_ff,
	input  wire tlc_pkg::tlc_ack_t ack,
	output logic                   ul_ready
);
	import tlc_pkg::*;
	logic [7:0] tmr_ff;
	logic [1:0] stall_ff;

	// ==========================================================
	// command issue and response supervision
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_ff <= 1'b0;
			acked_ff <= 1'b0;
			tmo_ff <= 1'b0;
			cmd_valid_ff <= 1'b0;
			cmd_out_ff <= '0;
			tmr_ff <= '0;
		end else if (go && !busy_ff) begin
			cmd_valid_ff <= 1'b1;
			cmd_out_ff <= cmd;
			busy_ff <= 1'b1;
			acked_ff <= 1'b0;
			tmo_ff <= 1'b0;
			tmr_ff <= '0;
		end else begin
			cmd_valid_ff <= 1'b0;
			// idle command lines wander so a stale value never passes
			cmd_out_ff <= ~cmd_out_ff;
			if (busy_ff && (ack.close_done || ack.open_done)) begin
				busy_ff <= 1'b0;
				acked_ff <= 1'b1;
			end else if (busy_ff && tmr_ff == TMO[7:0]) begin
				busy_ff <= 1'b0;
				tmo_ff <= 1'b1;
			end else if (busy_ff) begin
				tmr_ff <= tmr_ff + 8'h01;
			end
		end
	end

	// ==========================================================
	// uplink sink stalls one cycle in four
	always_ff @(posedge clk) begin
		if (rst) begin
			stall_ff <= '0;
		end else begin
			stall_ff <= stall_ff + 2'h1;
		end
	end
	assign ul_ready = (stall_ff != 2'h3);
endmodule

//--- dv/terminal_test_loop_control_tb.sv
`timescale 1ns/1ps
module terminal_test_loop_control_tb;
	import tlc_pkg::*;
	logic         sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         err, go, busy, acked, tmo, cmd_valid, mtch;
	logic         dl_valid, dl_ready, ul_valid, ul_ready;
	logic [3:0]   drop;
	tlc_cmd_t     cmd, cmd_in;
	tlc_ack_t     ack;
	tlc_dl_beat_t dl;
	tlc_ul_beat_t ul;
	tlc_ul_beat_t ulq[$];
	logic [7:0]   src[$];
	logic [31:0]  bcfg[4] = '{32'h000b0003, 32'h000e0000, 32'h00080000,
		32'h000b0005};
	int           miscompares = 0;
	int           compares = 0;
	int           i;

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	tlc_loop_ctrl DUT (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CMD_IN(cmd_in), .CMD_VALID(cmd_valid),
		.ACK_OUT(ack), .BEARER_DROP(drop), .MTCH_SDU(mtch), .DL_IN(dl),
		.DL_VALID(dl_valid), .DL_READY(dl_ready), .UL_OUT(ul),
		.UL_VALID(ul_valid), .UL_READY(ul_ready));

	tlc_tester #(.TMO(20)) tester (
		.clk(sys_clk), .rst(sys_rst), .go(go), .cmd(cmd),
		.busy_ff(busy), .acked_ff(acked), .tmo_ff(tmo),
		.cmd_out_ff(cmd_in), .cmd_valid_ff(cmd_valid), .ack(ack),
		.ul_ready(ul_ready));

	always @(posedge sys_clk) begin
		if (ul_valid === 1'b1 && ul_ready === 1'b1) ulq.push_back(ul);
	end

	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int j;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (j = 0; j < 20; j++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	task automatic order(input logic op, input logic [1:0] m,
		input logic ex);
		int j;
		@(posedge sys_clk);
		go <= 1'b1;
		cmd <= '{open: op, mode: m};
		@(posedge sys_clk);
		go <= 1'b0;
		for (j = 0; j < 40; j++) begin
			@(posedge sys_clk);
			if (busy === 1'b0) break;
		end
		chk("ack", {31'h0, ex}, {31'h0, acked});
		chk("timeout", {31'h0, !ex}, {31'h0, tmo});
	endtask

	// sends src on bearer b, expects k returned bytes
	task automatic loop_sdu(input logic [1:0] b, input int k,
		input logic pd);
		int j, n;
		ulq.delete();
		@(posedge sys_clk);
		for (n = 0; n < src.size(); n++) begin
			dl_valid <= 1'b1;
			dl <= '{data: src[n], last: (n == src.size() - 1), bearer: b};
			for (j = 0; j < 50; j++) begin
				@(posedge sys_clk);
				if (dl_ready === 1'b1) break;
			end
		end
		dl_valid <= 1'b0;
		dl.data <= ~src[src.size() - 1];
		@(posedge sys_clk);
		for (j = 0; j < 200; j++) begin
			@(posedge sys_clk);
			if (dl_ready === 1'b1 && ul_valid === 1'b0) break;
		end
		chk("ul count", k, ulq.size());
		for (n = 0; n < ulq.size() && n < k; n++) begin
			chk("ul beat", {20'h0, src[n % src.size()], n == k - 1, b, pd},
				{20'h0, ulq[n]});
		end
	endtask

	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		wrap_up;
	end

	// ==========================================================
	// tests
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, go, mtch, dl_valid} = '0;
		paddr = '0;
		pwdata = '0;
		cmd = '0;
		drop = '0;
		dl = '0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("stat", OFS_STAT, 32'h0);
		apb(1'b1, OFS_CNT, 32'h5);
		rchk("cnt", OFS_CNT, 32'h0);
		rchk("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, OFS_FMT0, 32'h1234);
		rchk("fmt0", OFS_FMT0, 32'h1234);
		$display("test registers done");
		for (i = 0; i < 4; i++) apb(1'b1, OFS_BCFG0 + 8'(4 * i), bcfg[i]);
		order(1'b0, MODE_ONE, 1'b0);
		rchk("stat", OFS_STAT, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h3);
		order(1'b0, MODE_ONE, 1'b1);
		rchk("stat", OFS_STAT, 32'hb);
		rchk("bcfg0", OFS_BCFG0, 32'h005b0003);
		src = '{8'h11, 8'h22, 8'h33, 8'h44};
		loop_sdu(2'd0, 3, 1'b0);
		src = '{8'h55, 8'h66};
		loop_sdu(2'd1, 2, 1'b1);
		src = '{8'h77, 8'h88};
		loop_sdu(2'd3, 5, 1'b0);
		src = '{8'h99};
		loop_sdu(2'd2, 0, 1'b0);
		$display("test loopback done");
		order(1'b0, MODE_TWO, 1'b1);
		rchk("stat", OFS_STAT, 32'hb);
		@(posedge sys_clk);
		drop <= 4'h8;
		@(posedge sys_clk);
		drop <= 4'h0;
		rchk("stat", OFS_STAT, 32'h3);
		order(1'b1, 2'h0, 1'b1);
		rchk("stat", OFS_STAT, 32'h0);
		order(1'b1, 2'h0, 1'b1);
		apb(1'b1, OFS_BCFG0, 32'h000b0000);
		order(1'b0, MODE_ONE, 1'b1);
		src = '{8'h01, 8'h02};
		loop_sdu(2'd0, 0, 1'b0);
		order(1'b1, 2'h0, 1'b1);
		$display("test open done");
		apb(1'b1, OFS_FMT0 + 8'h04, 32'h3);
		order(1'b0, MODE_TWO, 1'b1);
		src = '{8'h12, 8'h34};
		loop_sdu(2'd1, 3, 1'b1);
		apb(1'b1, OFS_FMT0, 32'h2);
		src = '{8'h21, 8'h43, 8'h65, 8'h87};
		loop_sdu(2'd1, 3, 1'b1);
		order(1'b1, 2'h0, 1'b1);
		$display("test format done");
		order(1'b0, MODE_THREE, 1'b1);
		rchk("stat", OFS_STAT, 32'h100);
		rchk("cnt", OFS_CNT, 32'h0);
		@(posedge sys_clk);
		mtch <= 1'b1;
		repeat (3) @(posedge sys_clk);
		mtch <= 1'b0;
		rchk("cnt", OFS_CNT, 32'h3);
		$display("test count done");
		wrap_up;
	end
endmodule
